//--- ctc_pkg.sv
package ctc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFS_OTG_PRE   = 8'h0D;
    localparam logic [7:0] OFS_TIMER     = 8'h0E;
    localparam logic [7:0] OFS_CTRL0     = 8'h0F;
    localparam logic [7:0] RST_OTG_PRE   = 8'h4B;
    localparam logic [7:0] RST_TIMER     = 8'h3D;
    localparam logic [7:0] RST_CTRL0     = 8'hA2;
    // fields that a watchdog expiry restores, per register
    localparam logic [7:0] WD_MASK_OTG   = 8'hFF;
    localparam logic [7:0] WD_MASK_TIMER = 8'hFF;
    localparam logic [7:0] WD_MASK_CTRL0 = 8'h0A;
    localparam logic [7:0] RSV_MASK_CTRL0 = 8'hFE;
    localparam logic [6:0] OTG_MIN_CODE  = 7'h04;
    localparam int B_PRE_SEL   = 7;
    localparam int B_TRK_EN    = 5;
    localparam int B_PRE_EN    = 4;
    localparam int B_FAST_EN   = 3;
    localparam int B_HALF_EN   = 0;
    localparam int B_AUTO_DIS  = 7;
    localparam int B_FORCE_DIS = 6;
    localparam int B_CHG_EN    = 5;
    localparam int B_OPT_EN    = 4;
    localparam int B_OPT_GO    = 3;
    localparam int B_HIZ       = 2;
    localparam int B_TERM      = 1;
    // ****************************************
    // timing, charge limits in minutes as printed, watchdog period in seconds
    // ****************************************
    localparam int TRICKLE_MIN   = 60;
    localparam int PRE_LONG_MIN  = 120;
    localparam int PRE_SHORT_MIN = 30;
    localparam int FAST_MIN0     = 300;
    localparam int FAST_MIN1     = 480;
    localparam int FAST_MIN2     = 720;
    localparam int FAST_MIN3     = 1440;
    localparam int TOPOFF_STEP_MIN = 15;
    localparam int SEC_PER_MIN   = 60;
    localparam int WD_PERIOD_S   = 40;
    localparam int CLK_HZ        = 10_000_000;
    localparam int SECS_W        = 17;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        PH_IDLE, PH_TRICKLE, PH_PRECHARGE, PH_FAST, PH_TOPOFF
    } ctc_phase_t;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ctc_reg_req_t;
    typedef struct packed {
        logic       bat_ovp;
        logic       regulating;
        logic       adapter;
        logic       opt_started;
        ctc_phase_t phase;
    } ctc_pins_t;
endpackage

//--- ctc_regs.sv
`timescale 1ns/1ps
module ctc_regs #(
    parameter int TICK_CYCLES = ctc_pkg::CLK_HZ
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_arst_n,
    input  wire ctc_pkg::ctc_reg_req_t i_req,
    input  wire ctc_pkg::ctc_pins_t    i_pins,
    input  wire logic                  i_soft_reset,
    input  wire logic                  i_wd_restart,
    input  wire logic                  i_wd_stops_charge,
    output logic [7:0]                 o_rdata,
    output logic [6:0]                 o_otg_limit,
    output logic                       o_charge_enable,
    output logic                       o_term_enable,
    output logic                       o_hiz,
    output logic                       o_optimizer_enable,
    output logic                       o_optimizer_start,
    output logic                       o_discharge,
    output logic                       o_safety_expired,
    output logic                       o_wd_expired
);
    import ctc_pkg::*;

    // the tick counter is 27 bits wide and must wrap at least once
    if (TICK_CYCLES < 2 || TICK_CYCLES > 100_000_000) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0]        r_otg;
        logic [7:0]        r_tmr;
        logic [7:0]        r_ctl;
        ctc_pins_t         s1;
        ctc_pins_t         s2;
        logic              adp_d;
        logic [26:0]       tick_cnt;
        logic [5:0]        wd_s;
        logic              wd_exp;
        logic [SECS_W-1:0] safe_s;
        logic              half;
        logic              expired;
        ctc_phase_t        phase_d;
        logic              disch;
        logic [7:0]        rdata;
    } ctc_state_t;

    ctc_state_t state_reg;
    ctc_state_t state_next;

    // limit in seconds for a phase; zero means no timer runs
    function automatic logic [SECS_W-1:0] limit_s(ctc_phase_t ph,
            logic [7:0] ro, logic [7:0] rt);
        int m;
        m = 0;
        case (ph)
            PH_TRICKLE:   m = rt[B_TRK_EN] ? TRICKLE_MIN : 0;
            PH_PRECHARGE: begin
                if (rt[B_PRE_EN]) begin
                    m = ro[B_PRE_SEL] ? PRE_SHORT_MIN : PRE_LONG_MIN;
                end
            end
            PH_FAST: begin
                if (rt[B_FAST_EN]) begin
                    case (rt[2:1])
                        2'h0:    m = FAST_MIN0;
                        2'h1:    m = FAST_MIN1;
                        2'h2:    m = FAST_MIN2;
                        default: m = FAST_MIN3;
                    endcase
                end
            end
            PH_TOPOFF:    m = TOPOFF_STEP_MIN * int'(rt[7:6]);
            default:      m = 0;
        endcase
        return SECS_W'(m * SEC_PER_MIN);
    endfunction

    logic              tick;
    logic              slow;
    logic [SECS_W-1:0] lim;
    logic              go_keep;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        tick = (state_reg.tick_cnt == 27'(TICK_CYCLES - 1));
        // top-off keeps full rate; only the three charge timers slow down
        slow = state_reg.r_tmr[B_HALF_EN] && state_reg.s2.regulating
            && state_reg.s2.phase != PH_TOPOFF;
        lim = limit_s(state_reg.s2.phase, state_reg.r_otg, state_reg.r_tmr);
        go_keep = 1'b0;
        // pins cross into the clock domain through two stages
        state_next.s1 = i_pins;
        state_next.s2 = state_reg.s1;
        state_next.adp_d = state_reg.s2.adapter;
        state_next.tick_cnt = tick ? 27'h0 : state_reg.tick_cnt + 27'h1;
        state_next.phase_d = state_reg.s2.phase;
        state_next.wd_exp = 1'b0;

        // watchdog, counted in whole seconds
        if (i_wd_restart || i_soft_reset) begin
            state_next.wd_s = 6'h0;
        end else if (tick) begin
            if (state_reg.wd_s == 6'(WD_PERIOD_S - 1)) begin
                state_next.wd_s = 6'h0;
                state_next.wd_exp = 1'b1;
            end else begin
                state_next.wd_s = state_reg.wd_s + 6'h1;
            end
        end

        // safety timer restarts whenever the charge phase moves
        if (i_soft_reset || state_reg.s2.phase != state_reg.phase_d) begin
            state_next.safe_s = '0;
            state_next.expired = 1'b0;
            state_next.half = 1'b0;
        end else if (tick && lim != '0 && !state_reg.expired) begin
            state_next.half = slow ? !state_reg.half : 1'b0;
            if (!slow || state_reg.half) begin
                state_next.safe_s = state_reg.safe_s + 1'b1;
                if (state_reg.safe_s + 1'b1 >= lim) begin
                    state_next.expired = 1'b1;
                end
            end
        end

        // hardware clears; a software set below still wins
        if (state_reg.s2.opt_started) begin
            state_next.r_ctl[B_OPT_GO] = 1'b0;
        end
        if (state_reg.s2.adapter && !state_reg.adp_d) begin
            state_next.r_ctl[B_HIZ] = 1'b0;
        end

        if (i_req.wr) begin
            case (i_req.addr)
                OFS_OTG_PRE: begin
                    state_next.r_otg = i_req.wdata;
                    if (i_req.wdata[6:0] < OTG_MIN_CODE) begin
                        state_next.r_otg[6:0] = OTG_MIN_CODE;
                    end
                end
                OFS_TIMER: state_next.r_tmr = i_req.wdata;
                OFS_CTRL0: begin
                    // written data must never reach force start directly
                    go_keep = state_next.r_ctl[B_OPT_GO];
                    state_next.r_ctl = i_req.wdata
                        & RSV_MASK_CTRL0;
                    // force start only takes a one, and only when enabled
                    state_next.r_ctl[B_OPT_GO] = go_keep
                        || (i_req.wdata[B_OPT_GO]
                            && state_reg.r_ctl[B_OPT_EN]);
                end
                default: ;
            endcase
        end

        if (state_reg.wd_exp) begin
            state_next.r_otg = (state_next.r_otg & ~WD_MASK_OTG)
                | (RST_OTG_PRE & WD_MASK_OTG);
            state_next.r_tmr = (state_next.r_tmr & ~WD_MASK_TIMER)
                | (RST_TIMER & WD_MASK_TIMER);
            state_next.r_ctl = (state_next.r_ctl & ~WD_MASK_CTRL0)
                | (RST_CTRL0 & WD_MASK_CTRL0);
            if (i_wd_stops_charge) begin
                state_next.r_ctl[B_CHG_EN] = 1'b0;
            end
        end
        if (i_soft_reset) begin
            state_next.r_otg = RST_OTG_PRE;
            state_next.r_tmr = RST_TIMER;
            state_next.r_ctl = RST_CTRL0;
        end

        state_next.disch = state_reg.r_ctl[B_FORCE_DIS]
            || (state_reg.r_ctl[B_AUTO_DIS] && state_reg.s2.bat_ovp);
        case (i_req.addr)
            OFS_OTG_PRE: state_next.rdata = state_reg.r_otg;
            OFS_TIMER:   state_next.rdata = state_reg.r_tmr;
            OFS_CTRL0:   state_next.rdata = state_reg.r_ctl & RSV_MASK_CTRL0;
            default:     state_next.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= '{r_otg: RST_OTG_PRE, r_tmr: RST_TIMER,
                           r_ctl: RST_CTRL0, phase_d: PH_IDLE,
                           s1: '{phase: PH_IDLE, default: 1'b0},
                           s2: '{phase: PH_IDLE, default: 1'b0},
                           default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_rdata            = state_reg.rdata;
    assign o_otg_limit        = state_reg.r_otg[6:0];
    assign o_charge_enable    = state_reg.r_ctl[B_CHG_EN];
    assign o_term_enable      = state_reg.r_ctl[B_TERM];
    assign o_hiz              = state_reg.r_ctl[B_HIZ];
    assign o_optimizer_enable = state_reg.r_ctl[B_OPT_EN];
    assign o_optimizer_start  = state_reg.r_ctl[B_OPT_GO];
    assign o_discharge        = state_reg.disch;
    assign o_safety_expired   = state_reg.expired;
    assign o_wd_expired       = state_reg.wd_exp;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    sequence s_ovp_seen;
        state_reg.s2.bat_ovp && state_reg.r_ctl[B_AUTO_DIS];
    endsequence
    property p_otg_clamp;
        i_req.wr && i_req.addr == OFS_OTG_PRE
            && i_req.wdata[6:0] < OTG_MIN_CODE
            && !i_soft_reset && !state_reg.wd_exp
            |=> state_reg.r_otg[6:0] == OTG_MIN_CODE;
    endproperty
    a_otg_clamp: assert property (p_otg_clamp) else $error("otg below min");
    property p_auto_dis;
        s_ovp_seen |-> ##1 o_discharge;
    endproperty
    a_auto_dis: assert property (p_auto_dis) else $error("no auto discharge");
    property p_force_dis;
        state_reg.r_ctl[B_FORCE_DIS] |=> o_discharge;
    endproperty
    a_force_dis: assert property (p_force_dis) else $error("no forced discharge");
    property p_soft_rst;
        i_soft_reset |=> state_reg.r_ctl == RST_CTRL0 && state_reg.safe_s == '0;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset missed");
    property p_opt_set;
        i_req.wr && i_req.addr == OFS_CTRL0 && i_req.wdata[B_OPT_GO]
            && !state_reg.r_ctl[B_OPT_EN] && !state_reg.r_ctl[B_OPT_GO]
            && !i_soft_reset |=> !o_optimizer_start;
    endproperty
    a_opt_set: assert property (p_opt_set) else $error("force start while off");
    property p_opt_keep;
        state_reg.wd_exp && state_reg.r_ctl[B_OPT_EN] && !i_soft_reset
            && !(i_req.wr && i_req.addr == OFS_CTRL0)
            |=> o_optimizer_enable;
    endproperty
    a_opt_keep: assert property (p_opt_keep) else $error("optimizer enable lost");
    property p_wd_stop;
        state_reg.wd_exp && i_wd_stops_charge && !i_soft_reset |=> !o_charge_enable;
    endproperty
    a_wd_stop: assert property (p_wd_stop) else $error("charge not stopped");
    property p_wd_restore;
        state_reg.wd_exp && !i_soft_reset |=> state_reg.r_tmr == RST_TIMER;
    endproperty
    a_wd_restore: assert property (p_wd_restore) else $error("timer reg kept");
    property p_rsv;
        ##1 1 |-> o_rdata[0] == 1'b0 || $past(i_req.addr) != OFS_CTRL0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_hiz_clear;
        state_reg.s2.adapter && !state_reg.adp_d && !i_req.wr |=> !o_hiz;
    endproperty
    a_hiz_clear: assert property (p_hiz_clear) else $error("hiz kept");
endmodule

//--- ctc_host.sv
`timescale 1ns/1ps
// ****************************************
// host side of the register port
// ****************************************
module ctc_host
    import ctc_pkg::*;
(
    input  wire logic             i_mclk,
    input  wire logic [7:0]       i_rdata,
    output ctc_pkg::ctc_reg_req_t o_req,
    output logic                  o_soft_reset,
    output logic                  o_wd_restart
);
    initial begin
        o_req = '0;
        o_soft_reset = 1'b0;
        o_wd_restart = 1'b0;
    end
    // write strobe stands for exactly one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_req <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge i_mclk);
        o_req.wr <= 1'b0;
    endtask
    // read data is registered, so sample one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_req.addr <= a;
        @(posedge i_mclk);
        #1 d = i_rdata;
    endtask
    task automatic soft_rst();
        @(posedge i_mclk);
        o_soft_reset <= 1'b1;
        @(posedge i_mclk);
        o_soft_reset <= 1'b0;
    endtask
    task automatic wd_kick();
        @(posedge i_mclk);
        o_wd_restart <= 1'b1;
        @(posedge i_mclk);
        o_wd_restart <= 1'b0;
    endtask
endmodule

//--- charger_timer_control_regs_tb.sv
`timescale 1ns/1ps
module charger_timer_control_regs_tb;
    import ctc_pkg::*;
    logic         i_mclk, i_arst_n, wd_stop, soft_rst, wd_rst;
    ctc_reg_req_t req;
    ctc_pins_t    pins;
    logic [7:0]   rdata, v;
    logic [6:0]   otg;
    logic         chg, term, hiz, opt_en, opt_go, dis, safe_exp, wd_exp;
    int           mismatches, n_tests, cnt;
    ctc_regs #(.TICK_CYCLES(10)) i_dut (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_req(req), .i_pins(pins),
        .i_soft_reset(soft_rst), .i_wd_restart(wd_rst),
        .i_wd_stops_charge(wd_stop), .o_rdata(rdata), .o_otg_limit(otg),
        .o_charge_enable(chg), .o_term_enable(term), .o_hiz(hiz),
        .o_optimizer_enable(opt_en), .o_optimizer_start(opt_go),
        .o_discharge(dis), .o_safety_expired(safe_exp),
        .o_wd_expired(wd_exp));
    ctc_host i_host (
        .i_mclk(i_mclk), .i_rdata(rdata), .o_req(req),
        .o_soft_reset(soft_rst), .o_wd_restart(wd_rst));
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic close_out();
        if (mismatches == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, v);
        chk(v, exp);
    endtask
    task automatic settle();
        repeat (5) @(posedge i_mclk);
        #1;
    endtask
    // long waits keep the watchdog fed so the settings survive
    task automatic run(input int n);
        for (int i = 0; i < n; i++) begin
            if (i % 100 == 0) i_host.wd_kick();
            else @(posedge i_mclk);
        end
        #1;
    endtask
    task automatic wd_wait();
        i_host.wd_kick();
        cnt = 0;
        while (wd_exp !== 1'b1 && cnt < 1000) begin
            @(posedge i_mclk);
            #1 cnt++;
        end
        if (cnt >= 1000) begin
            mismatches++;
            close_out();
        end
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        i_arst_n = 1'b0;
        wd_stop = 1'b0;
        pins = '0;
        repeat (10) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        rchk(OFS_OTG_PRE, RST_OTG_PRE);
        rchk(OFS_TIMER, RST_TIMER);
        rchk(OFS_CTRL0, RST_CTRL0);
        rchk(8'h0C, 8'h00);
        chk({1'b0, otg}, 8'h4B);
        chk({chg, term, hiz, opt_en, opt_go, dis}, 8'h30);
        for (int k = 0; k < 4; k++) begin
            v = {k[1:0], k[0], ~k[0], k[1], k[1:0], ~k[1]};
            i_host.wr(OFS_TIMER, v);
            rchk(OFS_TIMER, v);
        end
        i_host.wr(OFS_OTG_PRE, 8'h83);
        rchk(OFS_OTG_PRE, 8'h84);
        i_host.wr(OFS_OTG_PRE, 8'h7F);
        rchk(OFS_OTG_PRE, 8'h7F);
        chk({1'b0, otg}, 8'h7F);
        // force start is refused while the optimizer was still off
        i_host.wr(OFS_CTRL0, 8'hFF);
        rchk(OFS_CTRL0, 8'hF6);
        chk({hiz, dis, opt_go}, 8'h06);
        i_host.wr(OFS_CTRL0, 8'hFF);
        rchk(OFS_CTRL0, 8'hFE);
        chk(opt_go, 1'b1);
        i_host.wr(OFS_CTRL0, 8'hF6);
        rchk(OFS_CTRL0, 8'hFE);
        @(posedge i_mclk);
        pins.opt_started <= 1'b1;
        settle();
        chk(opt_go, 1'b0);
        @(posedge i_mclk);
        pins.opt_started <= 1'b0;
        pins.adapter <= 1'b1;
        settle();
        chk(hiz, 1'b0);
        @(posedge i_mclk);
        pins.adapter <= 1'b0;
        i_host.wr(OFS_CTRL0, 8'h80);
        settle();
        chk(dis, 1'b0);
        @(posedge i_mclk);
        pins.bat_ovp <= 1'b1;
        settle();
        chk(dis, 1'b1);
        i_host.wr(OFS_CTRL0, 8'h00);
        settle();
        chk({dis, chg, term}, 8'h00);
        @(posedge i_mclk);
        pins.bat_ovp <= 1'b0;
        i_host.wd_kick();
        i_host.wr(OFS_CTRL0, 8'h10);
        i_host.wr(OFS_OTG_PRE, 8'h11);
        i_host.soft_rst();
        rchk(OFS_OTG_PRE, RST_OTG_PRE);
        rchk(OFS_CTRL0, RST_CTRL0);
        // expiry restores watchdog fields, optimizer enable survives
        i_host.wr(OFS_CTRL0, 8'h10);
        i_host.wr(OFS_OTG_PRE, 8'h11);
        i_host.wr(OFS_TIMER, 8'h00);
        wd_wait();
        // restart does not realign the second tick: one tick of slack
        chk(cnt >= 391 && cnt <= 400, 1'b1);
        rchk(OFS_OTG_PRE, RST_OTG_PRE);
        rchk(OFS_TIMER, RST_TIMER);
        rchk(OFS_CTRL0, 8'h12);
        @(posedge i_mclk);
        wd_stop <= 1'b1;
        i_host.wr(OFS_CTRL0, 8'h30);
        wd_wait();
        rchk(OFS_CTRL0, 8'h12);
        @(posedge i_mclk);
        wd_stop <= 1'b0;
        // short precharge limit, regulating but half rate off
        i_host.wr(OFS_OTG_PRE, 8'hCB);
        i_host.wr(OFS_TIMER, 8'h3C);
        @(posedge i_mclk);
        pins.regulating <= 1'b1;
        pins.phase <= PH_PRECHARGE;
        run(17000);
        chk(safe_exp, 1'b0);
        run(2000);
        chk(safe_exp, 1'b1);
        @(posedge i_mclk);
        pins.phase <= PH_IDLE;
        i_host.wr(OFS_TIMER, 8'h3D);
        settle();
        chk(safe_exp, 1'b0);
        @(posedge i_mclk);
        pins.phase <= PH_PRECHARGE;
        run(19000);
        chk(safe_exp, 1'b0);
        close_out();
    end
endmodule
